// >>> wide_and_table_compare.sv
// pair and table compare engine with data memory behind an avalon-mm slave
`timescale 1ns/1ps
`default_nettype none

module wide_and_table_compare
    import cmp_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic irq,
    output logic above_flag,
    output logic same_flag,
    output logic below_flag,
    output logic fault_flag,
    output logic busy
);

    typedef struct packed {
        logic [DM_WORDS-1:0][15:0] data_memory;
        logic cond;
        logic repeat_en;
        logic [7:0] pair_code;
        logic [15:0] first_operand_pair;
        logic [15:0] second_operand_pair;
        logic [15:0] result_op;
        logic have_op;
        logic op_table;
        eng_state_t st;
        logic [4:0] idx;
        logic [15:0] mism;
        logic [DM_AW-1:0] a_addr;
        logic [DM_AW-1:0] b_addr;
        logic [DM_AW-1:0] r_addr;
        logic above;
        logic same;
        logic below;
        logic fault;
        logic [STAT_W-1:0] status;
        logic [STAT_W-1:0] irq_mask;
        logic [DM_AW-1:0] mem_addr;
        logic [31:0] rdata;
        logic wait_n;
        logic irq;
        logic busy;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    // byte-lane merge of a write into a register image
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
                                                input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
                res[i*8 +: 8] = wd[i*8 +: 8];
        end
        return res;
    endfunction : lane_merge

    // effective address of an operand field; msb of result flags a bad pointer
    function automatic logic [DM_AW:0] resolve(input logic [15:0] op,
                                                input logic [DM_WORDS-1:0][15:0] m);
        logic [15:0] w;
        logic [13:0] val;
        logic bad;
        w = m[op[DM_AW-1:0]];
        bad = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            if (w[i*4 +: 4] > 4'h9)
                bad = 1'b1;
        end
        val = 14'(w[15:12]) * 14'd1000 + 14'(w[11:8]) * 14'd100 + 14'(w[7:4]) * 14'd10
            + 14'(w[3:0]);
        if (val >= 14'(DM_WORDS))
            bad = 1'b1;
        if (!op[OP_IND_BIT])
            return {1'b0, op[DM_AW-1:0]};
        return {bad, val[DM_AW-1:0]};
    endfunction : resolve

    // true when base plus span leaves the data area
    function automatic logic runs_past(input logic [DM_AW-1:0] base, input logic [4:0] span);
        logic [DM_AW:0] last;
        last = {1'b0, base} + {4'h0, span};
        return last[DM_AW];
    endfunction : runs_past

    logic [DM_AW:0] res_a;
    logic [DM_AW:0] res_b;
    logic [DM_AW:0] res_r;
    logic [31:0] pair_x;
    logic [31:0] pair_y;
    logic req;
    logic blocked;
    logic accept;
    logic [31:0] reg_view;
    logic [STAT_W-1:0] stat_set;
    logic [STAT_W-1:0] stat_clr;
    logic issue;
    logic issue_table;

    always_comb
    begin
        s_nxt = s_r;
        stat_set = '0;
        stat_clr = '0;
        issue = 1'b0;
        issue_table = s_r.op_table;
        reg_view = 32'h0000_0000;

        res_a = resolve(s_r.first_operand_pair, s_r.data_memory);
        res_b = resolve(s_r.second_operand_pair, s_r.data_memory);
        res_r = resolve(s_r.result_op, s_r.data_memory);
        pair_x = {s_r.data_memory[s_r.a_addr + 8'h01], s_r.data_memory[s_r.a_addr]};
        pair_y = {s_r.data_memory[s_r.b_addr + 8'h01], s_r.data_memory[s_r.b_addr]};

        // bus access: one wait state, memory port held off while the engine owns it
        req = read | write;
        blocked = s_r.busy && (address == OFS_MEM_DATA);
        accept = req && !s_r.wait_n;

        case (address)
            OFS_CTRL: reg_view = {16'h0000, s_r.pair_code, 6'h00, s_r.repeat_en, s_r.cond};
            OFS_CMD: reg_view = {31'h0, s_r.busy};
            OFS_OPA: reg_view = {16'h0000, s_r.first_operand_pair};
            OFS_OPB: reg_view = {16'h0000, s_r.second_operand_pair};
            OFS_OPR: reg_view = {16'h0000, s_r.result_op};
            OFS_FLAGS: reg_view = {28'h0, s_r.fault, s_r.below, s_r.same, s_r.above};
            OFS_STATUS: reg_view = {30'h0, s_r.status};
            OFS_MASK: reg_view = {30'h0, s_r.irq_mask};
            OFS_MEM_ADDR: reg_view = {24'h0, s_r.mem_addr};
            OFS_MEM_DATA: reg_view = {16'h0000, s_r.data_memory[s_r.mem_addr]};
            default: reg_view = 32'h0000_0000;
        endcase

        if (req && s_r.wait_n && !blocked)
        begin
            s_nxt.wait_n = 1'b0;
            if (read)
                s_nxt.rdata = reg_view;
        end
        else
        begin
            s_nxt.wait_n = 1'b1;
        end

        if (accept && read)
        begin
            // clear only what was actually returned, so a late event survives
            if (address == OFS_STATUS)
                stat_clr = s_r.rdata[STAT_W-1:0];
            if (address == OFS_MEM_DATA)
                s_nxt.mem_addr = s_r.mem_addr + 8'h01;
        end

        if (accept && write)
        begin
            case (address)
                OFS_CTRL:
                begin
                    reg_view = lane_merge({16'h0000, s_r.pair_code, 6'h00, s_r.repeat_en, s_r.cond},
                                          writedata, byteenable);
                    s_nxt.cond = reg_view[CTRL_COND_BIT];
                    s_nxt.repeat_en = reg_view[CTRL_REPEAT_BIT];
                    s_nxt.pair_code = reg_view[CTRL_CODE_LSB +: 8];
                end
                OFS_CMD:
                begin
                    if (byteenable[0] && !s_r.busy)
                    begin
                        if (writedata[7:0] == s_r.pair_code)
                        begin
                            s_nxt.have_op = 1'b1;
                            s_nxt.op_table = 1'b0;
                            issue_table = 1'b0;
                            issue = s_r.cond;
                        end
                        else if (writedata[7:0] == TABLE_CODE)
                        begin
                            s_nxt.have_op = 1'b1;
                            s_nxt.op_table = 1'b1;
                            issue_table = 1'b1;
                            issue = s_r.cond;
                        end
                    end
                end
                OFS_OPA:
                begin
                    reg_view = lane_merge({16'h0000, s_r.first_operand_pair}, writedata, byteenable);
                    s_nxt.first_operand_pair = reg_view[15:0];
                end
                OFS_OPB:
                begin
                    reg_view = lane_merge({16'h0000, s_r.second_operand_pair}, writedata, byteenable);
                    s_nxt.second_operand_pair = reg_view[15:0];
                end
                OFS_OPR:
                begin
                    reg_view = lane_merge({16'h0000, s_r.result_op}, writedata, byteenable);
                    s_nxt.result_op = reg_view[15:0];
                end
                OFS_MASK:
                begin
                    if (byteenable[0])
                        s_nxt.irq_mask = writedata[STAT_W-1:0];
                end
                OFS_MEM_ADDR:
                begin
                    if (byteenable[0])
                        s_nxt.mem_addr = writedata[DM_AW-1:0];
                end
                OFS_MEM_DATA:
                begin
                    reg_view = lane_merge({16'h0000, s_r.data_memory[s_r.mem_addr]}, writedata, byteenable);
                    s_nxt.data_memory[s_r.mem_addr] = reg_view[15:0];
                    s_nxt.mem_addr = s_r.mem_addr + 8'h01;
                end
                default:
                begin
                    reg_view = 32'h0000_0000;
                end
            endcase
        end

        // compare engine
        case (s_r.st)
            S_IDLE:
            begin
                // each pass through idle is one scan; keep re-running while enabled
                // a pending memory-data access goes first, so no scan starts under it
                if (!issue && s_r.have_op && s_r.repeat_en && s_r.cond
                    && !(req && address == OFS_MEM_DATA))
                    issue = 1'b1;
                if (issue)
                begin
                    s_nxt.op_table = issue_table;
                    s_nxt.busy = 1'b1;
                    s_nxt.st = S_RESOLVE;
                end
            end
            S_RESOLVE:
            begin
                s_nxt.a_addr = res_a[DM_AW-1:0];
                s_nxt.b_addr = res_b[DM_AW-1:0];
                s_nxt.r_addr = res_r[DM_AW-1:0];
                s_nxt.idx = 5'h00;
                s_nxt.mism = 16'h0000;
                if (res_a[DM_AW] || res_b[DM_AW] || (s_r.op_table && res_r[DM_AW]))
                begin
                    s_nxt.fault = 1'b1;
                end
                else if (s_r.op_table && (runs_past(res_a[DM_AW-1:0], 5'(TABLE_LEN - 1))
                         || runs_past(res_b[DM_AW-1:0], 5'(TABLE_LEN - 1))))
                begin
                    s_nxt.fault = 1'b1;
                end
                else if (!s_r.op_table && (runs_past(res_a[DM_AW-1:0], 5'h01)
                         || runs_past(res_b[DM_AW-1:0], 5'h01)))
                begin
                    s_nxt.fault = 1'b1;
                end
                else
                begin
                    s_nxt.fault = 1'b0;
                end

                if (s_nxt.fault)
                begin
                    stat_set[STAT_FAULT_BIT] = 1'b1;
                    stat_set[STAT_DONE_BIT] = 1'b1;
                    s_nxt.busy = 1'b0;
                    s_nxt.st = S_IDLE;
                end
                else if (s_r.op_table)
                begin
                    s_nxt.st = S_TABLE;
                end
                else
                begin
                    s_nxt.st = S_PAIR;
                end
            end
            S_PAIR:
            begin
                // unsigned compare, one-hot result
                s_nxt.above = pair_x > pair_y;
                s_nxt.same = pair_x == pair_y;
                s_nxt.below = pair_x < pair_y;
                stat_set[STAT_DONE_BIT] = 1'b1;
                s_nxt.busy = 1'b0;
                s_nxt.st = S_IDLE;
            end
            S_TABLE:
            begin
                // one entry pair per clock keeps the memory to two read ports
                s_nxt.mism[s_r.idx[3:0]] = s_r.data_memory[s_r.a_addr + 8'(s_r.idx)]
                    != s_r.data_memory[s_r.b_addr + 8'(s_r.idx)];
                s_nxt.idx = s_r.idx + 5'h01;
                if (s_r.idx == 5'(TABLE_LEN - 1))
                    s_nxt.st = S_STORE;
            end
            S_STORE:
            begin
                s_nxt.data_memory[s_r.r_addr] = s_r.mism;
                s_nxt.same = s_r.mism == 16'h0000;
                stat_set[STAT_DONE_BIT] = 1'b1;
                s_nxt.busy = 1'b0;
                s_nxt.st = S_IDLE;
            end
            default:
            begin
                s_nxt.busy = 1'b0;
                s_nxt.st = S_IDLE;
            end
        endcase

        // sticky events: a set in the clearing cycle wins
        s_nxt.status = (s_r.status & ~stat_clr) | stat_set;
        s_nxt.irq = |(s_nxt.status & s_nxt.irq_mask);
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            s_r <= '0;
            s_r.pair_code <= PAIR_CODE_RST;
            s_r.first_operand_pair <= OP_RST;
            s_r.second_operand_pair <= OP_RST;
            s_r.result_op <= OP_RST;
            s_r.irq_mask <= MASK_RST;
            s_r.st <= S_IDLE;
            s_r.wait_n <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign readdata = s_r.rdata;
    assign waitrequest = s_r.wait_n;
    assign irq = s_r.irq;
    assign above_flag = s_r.above;
    assign same_flag = s_r.same;
    assign below_flag = s_r.below;
    assign fault_flag = s_r.fault;
    assign busy = s_r.busy;

endmodule : wide_and_table_compare

`default_nettype wire

// >>> cmp_pkg.sv
// constants, register map and state types for the compare datapath
package cmp_pkg;
    localparam int DM_WORDS = 256;
    localparam int DM_AW = 8;
    localparam int TABLE_LEN = 16;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_OPA = 8'h08;
    localparam logic [7:0] OFS_OPB = 8'h0c;
    localparam logic [7:0] OFS_OPR = 8'h10;
    localparam logic [7:0] OFS_FLAGS = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_MASK = 8'h1c;
    localparam logic [7:0] OFS_MEM_ADDR = 8'h20;
    localparam logic [7:0] OFS_MEM_DATA = 8'h24;

    // control register fields
    localparam int CTRL_COND_BIT = 0;
    localparam int CTRL_REPEAT_BIT = 1;
    localparam int CTRL_CODE_LSB = 8;
    localparam int CMD_BUSY_BIT = 0;

    // operand register fields
    localparam int OP_IND_BIT = 15;

    // flag register fields
    localparam int FLAG_ABOVE_BIT = 0;
    localparam int FLAG_SAME_BIT = 1;
    localparam int FLAG_BELOW_BIT = 2;
    localparam int FLAG_FAULT_BIT = 3;

    // status / mask fields
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_FAULT_BIT = 1;
    localparam int STAT_W = 2;

    // function codes
    localparam logic [7:0] PAIR_CODE_RST = 8'h3c;
    localparam logic [7:0] TABLE_CODE = 8'h13;

    // reset values
    localparam logic [15:0] OP_RST = 16'h0000;
    localparam logic [STAT_W-1:0] MASK_RST = 2'h0;

    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_RESOLVE = 5'b00010,
        S_PAIR = 5'b00100,
        S_TABLE = 5'b01000,
        S_STORE = 5'b10000
    } eng_state_t;
endpackage : cmp_pkg

// >>> cmp_asserts.sv
// concurrent checks on the compare block's bus handshake and flag outputs
`timescale 1ns/1ps
`default_nettype none
module cmp_asserts
    import cmp_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic waitrequest,
    input wire logic irq,
    input wire logic above_flag,
    input wire logic same_flag,
    input wire logic below_flag,
    input wire logic fault_flag,
    input wire logic busy
);
    default clocking dck @(posedge clock);
    endclocking
    default disable iff (reset);

    // memory data accesses may stall on a busy engine, so they are left out here
    sequence s_plain_access;
        (read || write) && waitrequest && address != OFS_MEM_DATA;
    endsequence
    sequence s_one_low;
        !waitrequest ##1 waitrequest;
    endsequence

    a_reset_quiet: assert property (disable iff (1'b0) reset |=> waitrequest && !irq && !busy && !fault_flag)
        else $error("outputs not at rest after reset");
    a_access_answer: assert property (s_plain_access |=> s_one_low)
        else $error("register access not answered in one cycle");
    a_wait_single: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_busy_stall: assert property ((read || write) && address == OFS_MEM_DATA && busy |-> waitrequest)
        else $error("memory access answered while engine busy");
    a_above_alone: assert property ($rose(above_flag) |-> !same_flag && !below_flag && !fault_flag)
        else $error("above flag raised beside another flag");
    a_below_alone: assert property ($rose(below_flag) |-> !same_flag && !above_flag && !fault_flag)
        else $error("below flag raised beside another flag");
    a_flags_hold: assert property (!busy && $past(!busy) && $past(!busy, 2) |-> $stable({above_flag, same_flag,
        below_flag, fault_flag}))
        else $error("flags changed with the engine idle");
    a_fault_keeps: assert property ($rose(fault_flag) |-> $stable({above_flag, same_flag, below_flag}))
        else $error("fault altered the compare flags");
endmodule : cmp_asserts

bind wide_and_table_compare cmp_asserts chk (.clock(clock), .reset(reset), .address(address), .read(read),
    .write(write), .waitrequest(waitrequest), .irq(irq), .above_flag(above_flag), .same_flag(same_flag),
    .below_flag(below_flag), .fault_flag(fault_flag), .busy(busy));
`default_nettype wire

// >>> sequencer_model.sv
// instruction sequencer model: issues register accesses as an avalon-mm master
`timescale 1ns/1ps
`default_nettype none
module sequencer_model
(
    input wire logic clock,
    input wire logic waitrequest,
    input wire logic [31:0] readdata,
    output logic [7:0] address,
    output logic read,
    output logic write,
    output logic [31:0] writedata,
    output logic [3:0] byteenable
);
    initial
    begin
        address = 8'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0000_0000;
        byteenable = 4'hf;
    end

    // iff sees waitrequest as it stood before the edge, so the answer edge is exact
    task automatic xfer(input logic is_wr, input logic [7:0] a, input logic [15:0] d, output logic [31:0] q);
        @(posedge clock);
        address <= a;
        read <= !is_wr;
        write <= is_wr;
        writedata <= {16'h0000, d};
        @(posedge clock iff !waitrequest);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : xfer
endmodule : sequencer_model
`default_nettype wire

// >>> tb_wide_and_table_compare.sv
// self-checking bench for the pair and table compare block
`timescale 1ns/1ps
`default_nettype none
module tb_wide_and_table_compare;
    import cmp_pkg::*;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [7:0] address;
    logic read, write, waitrequest, irq, above_flag, same_flag, below_flag, fault_flag, busy;
    logic [31:0] writedata, readdata, q;
    logic [3:0] byteenable;
    int errors = 0;
    int n_tests = 0;
    logic [31:0] va [4] = '{32'h0001_0000, 32'h1234_5678, 32'h0000_0001, 32'h8000_0000};
    logic [31:0] vb [4] = '{32'h0000_ffff, 32'h1234_5678, 32'h0000_0002, 32'h7fff_ffff};
    logic [2:0] ve [4] = '{3'h1, 3'h2, 3'h4, 3'h1};

    always #20 clock = ~clock;

    wide_and_table_compare uut (.clock(clock), .reset(reset), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .irq(irq), .above_flag(above_flag), .same_flag(same_flag), .below_flag(below_flag),
        .fault_flag(fault_flag), .busy(busy));
    sequencer_model sq (.clock(clock), .waitrequest(waitrequest), .readdata(readdata), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        sq.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        sq.xfer(1'b0, a, 16'h0000, q);
        chk(q, exp, what);
    endtask : rd_chk
    task automatic put(input logic [7:0] a, input logic [15:0] d);
        wr(OFS_MEM_ADDR, {8'h00, a});
        wr(OFS_MEM_DATA, d);
    endtask : put
    // bounded wait on the engine, sampled away from the launching edge
    task automatic settle();
        repeat (2) @(negedge clock);
        for (int i = 0; i < 100 && busy !== 1'b0; i++)
            @(negedge clock);
        chk({31'h0, busy}, 32'h0, "engine idle");
    endtask : settle
    task automatic run(input logic [7:0] code);
        wr(OFS_CMD, {8'h00, code});
        settle();
    endtask : run
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        #800000;
        errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        tally_and_finish();
    end

    initial
    begin
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        rd_chk(OFS_CTRL, 32'h0000_3c00, "ctrl reset");
        rd_chk(OFS_FLAGS, 32'h0, "flags reset");
        rd_chk(8'h40, 32'h0, "unmapped read");
        $display("test reset done");
        wr(OFS_MASK, 16'h0003);
        wr(OFS_CTRL, 16'h3c01);
        wr(OFS_OPA, 16'h000a);
        wr(OFS_OPB, 16'h0014);
        wr(OFS_OPR, 16'h0000);
        for (int k = 0; k < 4; k++)
        begin
            put(8'h0a, va[k][15:0]);
            put(8'h0b, va[k][31:16]);
            put(8'h14, vb[k][15:0]);
            put(8'h15, vb[k][31:16]);
            run(PAIR_CODE_RST);
            chk({31'h0, irq}, 32'h1, "irq raised");
            chk({28'h0, fault_flag, below_flag, same_flag, above_flag}, {29'h0, ve[k]}, "flag pins");
            rd_chk(OFS_FLAGS, {29'h0, ve[k]}, "pair flags");
            rd_chk(OFS_STATUS, 32'h1, "status done");
        end
        wr(OFS_CTRL, 16'h3c00);
        chk({31'h0, irq}, 32'h0, "irq cleared by read");
        put(8'h14, 16'h0000);
        put(8'h15, 16'h8000);
        run(PAIR_CODE_RST);
        rd_chk(OFS_FLAGS, 32'h1, "false condition");
        wr(OFS_CTRL, 16'h4101);
        run(PAIR_CODE_RST);
        rd_chk(OFS_FLAGS, 32'h1, "old code ignored");
        run(8'h41);
        rd_chk(OFS_FLAGS, 32'h2, "new code");
        $display("test pair done");
        put(8'h30, 16'h0010);
        put(8'h31, 16'h001a);
        wr(OFS_OPA, 16'h8030);
        run(8'h41);
        rd_chk(OFS_FLAGS, 32'h2, "indirect pointer");
        wr(OFS_OPA, 16'h8031);
        run(8'h41);
        rd_chk(OFS_FLAGS, 32'ha, "non-decimal pointer");
        chk({31'h0, fault_flag}, 32'h1, "fault pin");
        rd_chk(OFS_STATUS, 32'h3, "status fault");
        $display("test indirect done");
        wr(OFS_MASK, 16'h0000);
        for (int i = 0; i < 16; i++)
        begin
            put(8'h40 + 8'(i), 16'(i));
            put(8'h60 + 8'(i), (i == 0 || i == 3 || i == 15) ? 16'(i) + 16'h0100 : 16'(i));
        end
        wr(OFS_OPA, 16'h0040);
        wr(OFS_OPB, 16'h0060);
        wr(OFS_OPR, 16'h0080);
        run(TABLE_CODE);
        chk({31'h0, irq}, 32'h0, "masked irq");
        wr(OFS_MEM_ADDR, 16'h0080);
        rd_chk(OFS_MEM_DATA, 32'h8009, "mismatch mask");
        rd_chk(OFS_FLAGS, 32'h0, "table flags");
        put(8'h60, 16'h0000);
        put(8'h63, 16'h0003);
        put(8'h6f, 16'h000f);
        wr(OFS_CTRL, 16'h4100);
        run(TABLE_CODE);
        wr(OFS_MEM_ADDR, 16'h0080);
        rd_chk(OFS_MEM_DATA, 32'h8009, "table false condition");
        wr(OFS_CTRL, 16'h4101);
        run(TABLE_CODE);
        wr(OFS_MEM_ADDR, 16'h0080);
        rd_chk(OFS_MEM_DATA, 32'h0, "tables equal");
        rd_chk(OFS_FLAGS, 32'h2, "table same");
        wr(OFS_OPB, 16'h00f8);
        run(TABLE_CODE);
        rd_chk(OFS_FLAGS, 32'ha, "table past end");
        $display("test table done");
        wr(OFS_OPB, 16'h0060);
        wr(OFS_CTRL, 16'h4103);
        wr(OFS_CMD, {8'h00, TABLE_CODE});
        rd_chk(OFS_CMD, 32'h1, "busy bit");
        put(8'h65, 16'h0077);
        repeat (60) @(posedge clock);
        wr(OFS_CTRL, 16'h4100);
        settle();
        wr(OFS_MEM_ADDR, 16'h0080);
        rd_chk(OFS_MEM_DATA, 32'h0020, "repeated pass");
        $display("test repeat done");
        tally_and_finish();
    end
endmodule : tb_wide_and_table_compare
`default_nettype wire
